// [cycle_if.sv]
// Request and answer carrier between the register front end and the pin engine.
interface cycle_if;
	import dpram_host_pkg::*;

	logic req;                  // One-cycle start pulse.
	logic wr;                   // Write when high, read when low.
	logic token;                // Token latch access instead of the array.
	logic flow;                 // Add the flow-through wait to reads.
	logic [ADDR_W-1:0] addr;    // Word or token address.
	logic [DATA_W-1:0] wdata;   // Write data.
	logic [DATA_W-1:0] rdata;   // Captured read data.
	logic done;                 // One-cycle completion pulse.
	logic active;               // Engine is running a cycle.

	modport ctrl (output req, wr, token, flow, addr, wdata, input rdata, done, active);
	modport eng (input req, wr, token, flow, addr, wdata, output rdata, done, active);
endinterface

// [dpram_host.sv]
// AHB-Lite register front end that drives one port of the dual-port memory.
module dpram_host
	import dpram_host_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Device port pins.
	output logic [dpram_host_pkg::ADDR_W-1:0] dev_addr,
	input wire logic [dpram_host_pkg::DATA_W-1:0] dev_data_i,
	output logic [dpram_host_pkg::DATA_W-1:0] dev_data_o,
	output logic dev_data_oe_n,
	output logic port_select_n,
	output logic token_latch_select_n,
	output logic read_drive_n,
	output logic write_strobe_n,
	// Flags and strap.
	input wire logic busy_n,
	input wire logic mailbox_n,
	output logic role_select
);
	import dpram_host_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cycle_if cyc ();                             // Carrier to the pin engine.
	logic [7:0] aph_addr_q, aph_addr_d;          // Latched address-phase offset.
	logic wr_ph_q, wr_ph_d;                      // A write data phase is due.
	logic rd_ph_q, rd_ph_d;                      // A read is waiting one cycle.
	logic ready_q, ready_d;                      // Registered hreadyout.
	logic [31:0] hrdata_q, hrdata_d;
	logic [ADDR_W-1:0] addr_q, addr_d;           // Target address.
	logic [DATA_W-1:0] wdata_q, wdata_d;         // Write data.
	logic [DATA_W-1:0] rdata_q, rdata_d;         // Last read result.
	logic [1:0] cfg_q, cfg_d;                    // Role and flow-through wait.
	logic done_q, done_d;                        // Sticky completion flag.
	logic mbox_lvl_q, mbox_lvl_d;                // Mailbox flag sample.
	logic mbox_evt_q, mbox_evt_d;                // Sticky mailbox arrival.
	logic busy_lvl_q, busy_lvl_d;                // Busy pin sample.
	logic req_q, req_d, cwr_q, cwr_d, ctok_q, ctok_d;
	logic accept;                                // Address phase taken this edge.
	logic [31:0] status;
	logic [31:0] rd_mux;

	// ----------------------------------------------------------------
	// Pin engine
	// ----------------------------------------------------------------
	assign cyc.req = req_q;
	assign cyc.wr = cwr_q;
	assign cyc.token = ctok_q;
	assign cyc.flow = cfg_q[CFG_FLOW_BIT];
	assign cyc.addr = addr_q;
	assign cyc.wdata = wdata_q;

	pin_engine pin_engine_i (
		.hclk(hclk),
		.hresetn(hresetn),
		.cyc(cyc),
		.addr_o(dev_addr),
		.data_i(dev_data_i),
		.data_o(dev_data_o),
		.data_oe_n(dev_data_oe_n),
		.port_select_n(port_select_n),
		.token_latch_select_n(token_latch_select_n),
		.read_drive_n(read_drive_n),
		.write_strobe_n(write_strobe_n),
		.busy_n(busy_n)
	);

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	// Unmapped offsets read as zero and ignore writes.
	always_comb begin
		status = '0;
		status[ST_ACTIVE_BIT] = cyc.active || req_q;
		status[ST_DONE_BIT] = done_q;
		status[ST_MBOX_LVL_BIT] = mbox_lvl_q;
		status[ST_MBOX_EVT_BIT] = mbox_evt_q;
		status[ST_BUSY_LVL_BIT] = busy_lvl_q;
		if (aph_addr_q == ADDR_OFS) begin
			rd_mux = {{(32-ADDR_W){1'b0}}, addr_q};
		end else if (aph_addr_q == WDATA_OFS) begin
			rd_mux = {{(32-DATA_W){1'b0}}, wdata_q};
		end else if (aph_addr_q == RDATA_OFS) begin
			rd_mux = {{(32-DATA_W){1'b0}}, rdata_q};
		end else if (aph_addr_q == STATUS_OFS) begin
			rd_mux = status;
		end else if (aph_addr_q == CFG_OFS) begin
			rd_mux = {30'h0, cfg_q};
		end else begin
			rd_mux = 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Bus and register next values
	// ----------------------------------------------------------------
	// Writes complete with no wait; reads take one wait state so that a
	// register written just before is returned with its new value.
	assign accept = hsel && htrans[1] && hready;

	always_comb begin
		aph_addr_d = aph_addr_q;
		wr_ph_d = 1'b0;
		rd_ph_d = 1'b0;
		ready_d = 1'b1;
		hrdata_d = hrdata_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		cfg_d = cfg_q;
		done_d = done_q;
		req_d = 1'b0;
		cwr_d = cwr_q;
		ctok_d = ctok_q;
		mbox_lvl_d = !mailbox_n;
		busy_lvl_d = !busy_n;
		mbox_evt_d = mbox_evt_q;
		if (accept) begin
			aph_addr_d = haddr[7:0];
			wr_ph_d = hwrite;
			rd_ph_d = !hwrite;
			ready_d = hwrite;
		end
		if (rd_ph_q) begin
			hrdata_d = rd_mux;
		end
		if (wr_ph_q) begin
			if (aph_addr_q == CMD_OFS) begin
				// A start while a cycle runs is dropped, so pins never change mid-cycle.
				if (hwdata[CMD_GO_BIT] && !cyc.active && !req_q) begin
					req_d = 1'b1;
					cwr_d = hwdata[CMD_WRITE_BIT];
					ctok_d = hwdata[CMD_TOKEN_BIT];
					done_d = 1'b0;
				end
			end else if (aph_addr_q == ADDR_OFS) begin
				addr_d = hwdata[ADDR_W-1:0];
			end else if (aph_addr_q == WDATA_OFS) begin
				wdata_d = hwdata[DATA_W-1:0];
			end else if (aph_addr_q == STATUS_OFS) begin
				if (hwdata[ST_MBOX_EVT_BIT]) begin
					mbox_evt_d = 1'b0;
				end
			end else if (aph_addr_q == CFG_OFS) begin
				cfg_d = hwdata[1:0];
			end
		end
		if (cyc.done) begin
			done_d = 1'b1;
			if (!cwr_q) begin
				rdata_d = cyc.rdata;
			end
		end
		// A new mailbox assertion wins over a clear in the same cycle.
		if (!mailbox_n && !mbox_lvl_q) begin
			mbox_evt_d = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_addr_q <= 8'h00;
			wr_ph_q <= 1'b0;
			rd_ph_q <= 1'b0;
			ready_q <= 1'b1;
			hrdata_q <= 32'h0;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			cfg_q <= CFG_RESET;
			done_q <= 1'b0;
			mbox_lvl_q <= 1'b0;
			mbox_evt_q <= 1'b0;
			busy_lvl_q <= 1'b0;
			req_q <= 1'b0;
			cwr_q <= 1'b0;
			ctok_q <= 1'b0;
		end else begin
			aph_addr_q <= aph_addr_d;
			wr_ph_q <= wr_ph_d;
			rd_ph_q <= rd_ph_d;
			ready_q <= ready_d;
			hrdata_q <= hrdata_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			cfg_q <= cfg_d;
			done_q <= done_d;
			mbox_lvl_q <= mbox_lvl_d;
			mbox_evt_q <= mbox_evt_d;
			busy_lvl_q <= busy_lvl_d;
			req_q <= req_d;
			cwr_q <= cwr_d;
			ctok_q <= ctok_d;
		end
	end

	assign hreadyout = ready_q;
	assign hrdata = hrdata_q;
	assign hresp = 1'b0;
	assign role_select = cfg_q[CFG_ROLE_BIT];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		accept && !hwrite |=> !hreadyout ##1 hreadyout) else $error("Read wait state missing.");
	mailbox_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!mailbox_n && !mbox_lvl_q |=> mbox_evt_q) else $error("Mailbox arrival lost.");
	token_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		req_q && ctok_q |=> ##(SETUP_CYC) !token_latch_select_n && port_select_n)
		else $error("Token request did not use the token select.");
endmodule

// [dpram_host_pkg.sv]
// Constants shared by the dual-port memory host controller and its pin engine.
//
// Operation
// - Reads assert port select and read drive.
// - Token access uses token select, not port select.
// - Cross-port read waits flow-through delay.
// - Writing 0 requests token; bit zero only.
// - Hold writes until busy input settles.
// - Never assert port and token select together.
package dpram_host_pkg;

	// ----------------------------------------------------------------
	// Device geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 13;                 // 8K words.
	localparam int DATA_W = 9;                  // Widest organisation.
	localparam logic [12:0] MBOX_TO_RIGHT = 13'h1fff; // Left writes, right reads.
	localparam logic [12:0] MBOX_TO_LEFT = 13'h1ffe;  // Right writes, left reads.

	// ----------------------------------------------------------------
	// Register offsets (byte addresses of aligned words)
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] ADDR_OFS = 8'h04;
	localparam logic [7:0] WDATA_OFS = 8'h08;
	localparam logic [7:0] RDATA_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] CFG_OFS = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_WRITE_BIT = 1;
	localparam int CMD_TOKEN_BIT = 2;
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_MBOX_LVL_BIT = 2;
	localparam int ST_MBOX_EVT_BIT = 3;
	localparam int ST_BUSY_LVL_BIT = 4;
	localparam int CFG_ROLE_BIT = 0;
	localparam int CFG_FLOW_BIT = 1;
	localparam logic [1:0] CFG_RESET = 2'h1;   // Master role, no flow-through wait.

	// ----------------------------------------------------------------
	// Pin timing, least times in ns, converted at a 5 ns clock
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int ADDR_SETUP_NS = 10;
	localparam int BUSY_SETTLE_NS = 20;
	localparam int WRITE_PULSE_NS = 20;
	localparam int ACCESS_NS = 30;
	localparam int FLOW_NS = 30;                // Cross-port flow-through delay.
	localparam int RECOVER_NS = 10;
	localparam int SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETTLE_CYC = (BUSY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WPULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FLOW_CYC = (FLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Engine states.
	typedef enum logic [2:0] {E_IDLE, E_SETUP, E_SETTLE, E_STROBE, E_HOLD, E_RECOVER} eng_state_t;

endpackage

// [dpram_host_test.sv]
// Self-checking bench for the dual-port memory host controller.
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin bad_count++; \
	$display("CHECK FAILED %0t %s", $time, msg); end end
module dpram_host_test;
	import dpram_host_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite, contend, r_post, r_tok;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic [3:0] r_cmd;
	wire logic hreadyout, hresp, oe_n, ps_n, ts_n, rd_n, ws_n, busy_n, mailbox_n, role_select;
	wire logic [31:0] hrdata;
	wire logic [ADDR_W-1:0] dev_addr;
	wire logic [DATA_W-1:0] dout, din;
	int checked, bad_count, rd_run, rd_len, wr_run, wr_len, strobes;

	dpram_host dpram_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .dev_addr(dev_addr), .dev_data_i(din), .dev_data_o(dout),
		.dev_data_oe_n(oe_n), .port_select_n(ps_n), .token_latch_select_n(ts_n), .read_drive_n(rd_n),
		.write_strobe_n(ws_n), .busy_n(busy_n), .mailbox_n(mailbox_n), .role_select(role_select));
	dpram_port_model dpram_port_model_i (.addr(dev_addr), .din(dout), .oe_n(oe_n), .ps_n(ps_n),
		.ts_n(ts_n), .rd_n(rd_n), .ws_n(ws_n), .dq(din), .busy_n(busy_n), .mailbox_n(mailbox_n),
		.contend(contend), .r_post(r_post), .r_tok(r_tok), .r_cmd(r_cmd));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// Measure strobe lengths in clock cycles and count write strobes.
	always @(posedge hclk) begin
		rd_run <= rd_n ? 0 : rd_run + 1;
		if (rd_n && rd_run != 0) rd_len <= rd_run;
		wr_run <= ws_n ? 0 : wr_run + 1;
		if (ws_n && wr_run != 0) wr_len <= wr_run;
		if (!ws_n && wr_run == 0) strobes <= strobes + 1;
	end

	task test_done;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// One single AHB-Lite transfer; read data is taken at the data phase's closing edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	// Launch one device cycle; c is token, write, go.
	task automatic go(input logic [12:0] a, input logic [8:0] d, input logic [2:0] c);
		wr(ADDR_OFS, {19'h0, a});
		wr(WDATA_OFS, {23'h0, d});
		wr(CMD_OFS, {29'h0, c});
		// The engine takes the request one edge later; let a stale done flag clear first.
		repeat (3) @(posedge hclk);
	endtask
	task automatic wait_done;
		logic [31:0] st;
		int n;
		st = 32'h0;
		n = 0;
		while ((st[ST_DONE_BIT] !== 1'b1 || st[ST_ACTIVE_BIT] !== 1'b0) && n < 200) begin
			rd(STATUS_OFS, st);
			n++;
		end
		`CHK(n < 200, 1'b1, "device cycle never completed")
	endtask
	task automatic run_rd(input logic [12:0] a, input logic [2:0] c, output logic [31:0] q);
		go(a, 9'h000, c);
		wait_done;
		rd(RDATA_OFS, q);
	endtask

	// Reset values, idle pins and an unmapped offset.
	task automatic t_reset;
		logic [31:0] q;
		`CHK({ps_n, ts_n, rd_n, ws_n, oe_n, hresp}, 6'h3e, "pins after reset")
		rd(CFG_OFS, q);
		`CHK(q, {30'h0, CFG_RESET}, "config reset value")
		rd(STATUS_OFS, q);
		`CHK(q, 32'h0, "status reset value")
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, q);
		`CHK(q, 32'h0, "unmapped offset")
		$display("reset test finished");
	endtask

	// Array write and read, strobe lengths, flow-through wait and role strap.
	task automatic t_array;
		logic [31:0] q;
		go(13'h0123, 9'h15a, 3'h3);
		wait_done;
		`CHK(dpram_port_model_i.mem[13'h0123], 9'h15a, "array write")
		rd(ADDR_OFS, q);
		`CHK(q, 32'h0000_0123, "address readback")
		rd(WDATA_OFS, q);
		`CHK(q, 32'h0000_015a, "write data readback")
		`CHK(wr_len, WPULSE_CYC, "write strobe length")
		run_rd(13'h0123, 3'h1, q);
		`CHK(q, 32'h15a, "array read")
		`CHK(rd_len, ACCESS_CYC, "read drive length")
		wr(CFG_OFS, 32'h0);
		rd(CFG_OFS, q);
		`CHK(role_select, 1'b0, "slave strap")
		wr(CFG_OFS, 32'h3);
		run_rd(13'h0123, 3'h1, q);
		`CHK(q, 32'h15a, "read with flow wait")
		`CHK(rd_len, ACCESS_CYC + FLOW_CYC, "flow-through read length")
		wr(CFG_OFS, 32'h1);
		`CHK({ps_n, ts_n, role_select}, 3'h7, "idle after cycles")
		$display("array test finished");
	endtask

	// Mailbox words in both directions, flag release and sticky event.
	task automatic t_mailbox;
		logic [31:0] q;
		go(MBOX_TO_RIGHT, 9'h0c3, 3'h3);
		wait_done;
		`CHK(dpram_port_model_i.right_flag, 1'b1, "far flag set")
		`CHK(dpram_port_model_i.mem[MBOX_TO_RIGHT], 9'h0c3, "message stored")
		r_cmd <= 4'h9;
		r_post <= 1'b1;
		@(posedge hclk);
		r_post <= 1'b0;
		rd(STATUS_OFS, q);
		`CHK(q[3:2], 2'h3, "near flag and event")
		run_rd(MBOX_TO_LEFT, 3'h1, q);
		`CHK(q, 32'h009, "message read")
		rd(STATUS_OFS, q);
		`CHK(q[3:2], 2'h2, "flag released by read")
		wr(STATUS_OFS, 32'h8);
		rd(STATUS_OFS, q);
		`CHK(q[3], 1'b0, "event cleared")
		$display("mailbox test finished");
	endtask

	// Token request, denial and hand-over on release; contend is set, but busy stays high while port select is high.
	task automatic t_token;
		logic [31:0] q;
		contend <= 1'b1;
		go(13'h1ff3, 9'h1fe, 3'h7);
		wait_done;
		contend <= 1'b0;
		`CHK(dpram_port_model_i.own[0][3], 1'b1, "token taken by bit zero")
		run_rd(13'h0003, 3'h5, q);
		`CHK(q, 32'h000, "owned token reads zero")
		r_cmd <= 4'h3;
		r_tok <= 1'b1;
		@(posedge hclk);
		r_tok <= 1'b0;
		`CHK(dpram_port_model_i.own[1][3], 1'b0, "far request denied")
		go(13'h0003, 9'h001, 3'h7);
		wait_done;
		`CHK(dpram_port_model_i.own[1][3], 1'b1, "token passed on")
		run_rd(13'h0003, 3'h5, q);
		`CHK(q, 32'h1ff, "lost token reads ones")
		`CHK(dpram_port_model_i.illegal, 1'b0, "both selects low")
		$display("token test finished");
	endtask

	// An array write under contention waits with no strobe until busy clears.
	task automatic t_busy;
		logic [31:0] q;
		int s;
		contend <= 1'b1;
		s = strobes;
		go(13'h0200, 9'h077, 3'h3);
		repeat (40) @(posedge hclk);
		rd(STATUS_OFS, q);
		`CHK(q[4:0] & 5'h11, 5'h11, "active and busy shown")
		`CHK(strobes, s, "no strobe while busy")
		contend <= 1'b0;
		wait_done;
		`CHK(dpram_port_model_i.mem[13'h0200], 9'h077, "write after busy")
		$display("busy test finished");
	endtask

	initial begin
		{hresetn, hsel, hwrite, contend, r_post, r_tok} = 6'h0;
		{haddr, hwdata, htrans, r_cmd} = 70'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_array;
		t_mailbox;
		t_token;
		t_busy;
		test_done;
	end

	// Everything above needs a few thousand cycles at most.
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		test_done;
	end
endmodule

// [dpram_port_model.sv]
// Behavioural model of one device port, with the far port's actions commanded by the bench.
module dpram_port_model
	import dpram_host_pkg::*;
(
	// Near port pins.
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] din,
	input wire logic oe_n,
	input wire logic ps_n,
	input wire logic ts_n,
	input wire logic rd_n,
	input wire logic ws_n,
	output logic [DATA_W-1:0] dq,
	output logic busy_n,
	output logic mailbox_n,
	// Far port actions.
	input wire logic contend,
	input wire logic r_post,
	input wire logic r_tok,
	input wire logic [3:0] r_cmd
);
	logic [DATA_W-1:0] mem [0:8191]; // Shared array, 8K words.
	logic [DATA_W-1:0] rbuf = 9'h000; // Read output register.
	logic [DATA_W-1:0] last = 9'h000; // Last value driven, inverted once released.
	logic [7:0] own [2] = '{8'h00, 8'h00}; // Token owners, index 0 is this port.
	logic [7:0] req [2] = '{8'h00, 8'h00}; // Pending token requests.
	logic left_flag = 1'b0;
	logic right_flag = 1'b0;
	logic illegal = 1'b0;

	// Busy is shown with no delay; the far port is the fixed tie-break winner whenever the bench says so.
	assign busy_n = !(contend && !ps_n);
	assign mailbox_n = !left_flag;
	// A released bus shows the inverse of the last value so stale data never passes.
	assign dq = (!rd_n && !(ps_n && ts_n)) ? rbuf : ~last;

	// Token write by either port; only bit zero counts.
	task automatic tok_wr(input int p, input logic [2:0] i, input logic v);
		if (!v) begin
			req[p][i] = 1'b1;
			if (!own[1-p][i]) own[p][i] = 1'b1;
		end else begin
			req[p][i] = 1'b0;
			if (own[p][i]) begin
				own[p][i] = 1'b0;
				if (req[1-p][i]) own[1-p][i] = 1'b1;
			end
		end
	endtask

	// Read data is latched as the drive opens, so a token cannot change under it.
	always @(negedge rd_n) begin
		if (!ts_n) rbuf = {DATA_W{~own[0][addr[2:0]]}};
		else if (!ps_n) begin
			rbuf = mem[addr];
			if (addr == MBOX_TO_LEFT) left_flag = 1'b0;
		end
	end
	always @(posedge rd_n) last = rbuf;

	// Writes land at the rising strobe; a busy port's array write is lost.
	always @(posedge ws_n) begin
		if (!ts_n) tok_wr(0, addr[2:0], din[0]);
		else if (!ps_n && busy_n && !oe_n) begin
			mem[addr] = din;
			if (addr == MBOX_TO_RIGHT) right_flag = 1'b1;
		end
	end

	// Far port actions.
	always @(posedge r_post) begin
		mem[MBOX_TO_LEFT] = {5'h00, r_cmd};
		left_flag = 1'b1;
	end
	always @(posedge r_tok) tok_wr(1, r_cmd[2:0], r_cmd[3]);
	always @(negedge ps_n or negedge ts_n) if (!ps_n && !ts_n) illegal = 1'b1;
endmodule

// [pin_engine.sv]
// Pin sequencer that runs one read or write cycle on a device port.
module pin_engine
	import dpram_host_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Request side.
	cycle_if.eng cyc,
	// Device port pins.
	output logic [ADDR_W-1:0] addr_o,
	input wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe_n,
	output logic port_select_n,
	output logic token_latch_select_n,
	output logic read_drive_n,
	output logic write_strobe_n,
	input wire logic busy_n
);
	import dpram_host_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	eng_state_t st_q, st_d;                      // Sequencer state.
	logic [3:0] cnt_q, cnt_d;                    // Phase counter.
	logic wr_q, wr_d, tok_q, tok_d, flow_q, flow_d; // Latched request kind.
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] dout_q, dout_d, rdata_q, rdata_d;
	logic oe_n_q, oe_n_d, sel_n_q, sel_n_d, tsel_n_q, tsel_n_d;
	logic rd_n_q, rd_n_d, wr_n_q, wr_n_d, done_q, done_d;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Every pin changes only on a phase boundary, so the device sees clean
	// setup and hold around each strobe edge.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		tok_d = tok_q;
		flow_d = flow_q;
		addr_d = addr_q;
		dout_d = dout_q;
		rdata_d = rdata_q;
		oe_n_d = oe_n_q;
		sel_n_d = sel_n_q;
		tsel_n_d = tsel_n_q;
		rd_n_d = rd_n_q;
		wr_n_d = wr_n_q;
		done_d = 1'b0;
		case (st_q)
			E_IDLE: begin
				if (cyc.req) begin
					wr_d = cyc.wr;
					tok_d = cyc.token;
					flow_d = cyc.flow;
					addr_d = cyc.addr;
					// Token writes carry meaning on bit zero only; upper bits idle high.
					dout_d = cyc.token ? {{(DATA_W-1){1'b1}}, cyc.wdata[0]} : cyc.wdata;
					// Exactly one of the two selects falls, never both.
					sel_n_d = cyc.token;
					tsel_n_d = !cyc.token;
					oe_n_d = !cyc.wr;
					cnt_d = 4'(SETUP_CYC - 1);
					st_d = E_SETUP;
				end
			end
			E_SETUP: begin
				if (cnt_q == 4'h0) begin
					cnt_d = 4'(SETTLE_CYC - 1);
					st_d = E_SETTLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			E_SETTLE: begin
				// An array access waits while busy is low and then for a full
				// settle time; token latches are not arbitrated by busy.
				if (!tok_q && !busy_n) begin
					cnt_d = 4'(SETTLE_CYC - 1);
				end else if (cnt_q != 4'h0) begin
					cnt_d = cnt_q - 4'h1;
				end else if (wr_q) begin
					wr_n_d = 1'b0;
					cnt_d = 4'(WPULSE_CYC - 1);
					st_d = E_STROBE;
				end else begin
					rd_n_d = 1'b0;
					cnt_d = flow_q ? 4'(ACCESS_CYC + FLOW_CYC - 1) : 4'(ACCESS_CYC - 1);
					st_d = E_STROBE;
				end
			end
			E_STROBE: begin
				if (cnt_q != 4'h0) begin
					cnt_d = cnt_q - 4'h1;
				end else if (wr_q) begin
					// The rising write strobe is the capture edge in the device.
					wr_n_d = 1'b1;
					st_d = E_HOLD;
				end else begin
					rdata_d = data_i;
					rd_n_d = 1'b1;
					st_d = E_HOLD;
				end
			end
			E_HOLD: begin
				sel_n_d = 1'b1;
				tsel_n_d = 1'b1;
				oe_n_d = 1'b1;
				done_d = 1'b1;
				cnt_d = 4'(RECOVER_CYC - 1);
				st_d = E_RECOVER;
			end
			default: begin
				if (cnt_q == 4'h0) begin
					st_d = E_IDLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= E_IDLE;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			tok_q <= 1'b0;
			flow_q <= 1'b0;
			addr_q <= '0;
			dout_q <= '0;
			rdata_q <= '0;
			oe_n_q <= 1'b1;
			sel_n_q <= 1'b1;
			tsel_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			tok_q <= tok_d;
			flow_q <= flow_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
			rdata_q <= rdata_d;
			oe_n_q <= oe_n_d;
			sel_n_q <= sel_n_d;
			tsel_n_q <= tsel_n_d;
			rd_n_q <= rd_n_d;
			wr_n_q <= wr_n_d;
			done_q <= done_d;
		end
	end

	assign addr_o = addr_q;
	assign data_o = dout_q;
	assign data_oe_n = oe_n_q;
	assign port_select_n = sel_n_q;
	assign token_latch_select_n = tsel_n_q;
	assign read_drive_n = rd_n_q;
	assign write_strobe_n = wr_n_q;
	assign cyc.rdata = rdata_q;
	assign cyc.done = done_q;
	assign cyc.active = (st_q != E_IDLE);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Helper counter of how long the read drive has been low.
	logic [3:0] rd_low_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_low_q <= 4'h0;
		end else begin
			rd_low_q <= rd_n_q ? 4'h0 : rd_low_q + 4'h1;
		end
	end

	select_exclusive_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(!port_select_n && !token_latch_select_n)) else $error("Port and token select low together.");
	read_selected_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!read_drive_n |-> (!port_select_n || !token_latch_select_n) && data_oe_n)
		else $error("Read drive without a select or with data driven.");
	token_kind_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(token_latch_select_n) |-> $past(cyc.req) && $past(cyc.token) && port_select_n)
		else $error("Token select fell without a token request.");
	write_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(write_strobe_n) && port_select_n == 1'b0 |-> $past(busy_n, 1) && $past(busy_n, 2))
		else $error("Array write began while busy was low.");
	token_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!write_strobe_n && !token_latch_select_n |-> !data_oe_n && data_o[DATA_W-1:1] == '1)
		else $error("Token write drives unexpected data.");
	flow_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(read_drive_n) && flow_q |-> $past(rd_low_q) == 4'(ACCESS_CYC + FLOW_CYC - 1))
		else $error("Read ended before the flow-through wait.");
	write_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(write_strobe_n) |=> done_q ##1 !done_q) else $error("Write did not finish after strobe.");
endmodule
